// *** inc/tape_rx_params.svh ***
`ifndef TAPE_RX_PARAMS_SVH
`define TAPE_RX_PARAMS_SVH

// Clock period in picoseconds
`define CLK_PERIOD_PS 5000
// Oversampling ticks per unit element
`define OVERSAMPLE 16
// Unit element lengths in microseconds, one per rate selection
`define UNIT_US_455 22000
`define UNIT_US_500 20000
`define UNIT_US_569 17500
`define UNIT_US_742 13500
// Clock cycles per oversample tick, rounded down
// Cycles per microsecond taken first so slow rates stay inside 32 bits
`define TICK_CYC(us) ((us) * (1000000 / `CLK_PERIOD_PS) / `OVERSAMPLE)
// Fallback sampling point within an element, used when sample_pt is out of range
`define SAMPLE_PT_RST 4'h8
// Number of data elements per frame
`define DATA_BITS 5
// Function cycle timing in fixed-rate ticks
`define FUNC_TICK_CYC 2000
`define PUNCH_LEN 16'h0010
`define FEED_START 16'h0018
`define FEED_LEN 16'h0008
`define FUNC_LEN 16'h0028

`endif

// *** inc/tape_rx_pkg.sv ***
package tape_rx_pkg;
  typedef enum logic [1:0] {
    SEL_IDLE  = 2'b00,
    SEL_START = 2'b01,
    SEL_DATA  = 2'b11,
    SEL_STOP  = 2'b10
  } sel_state_e;

  typedef enum logic [1:0] {
    FN_IDLE  = 2'b00,
    FN_PUNCH = 2'b01,
    FN_GAP   = 2'b11,
    FN_FEED  = 2'b10
  } fn_state_e;

  typedef logic [1:0] rate_t;
endpackage

// *** design/code_hold.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "tape_rx_params.svh"

// One-entry holding store between selecting and function stages
module code_hold #(
  parameter int W = 5
) (
  input  wire logic         mclk,
  input  wire logic         sys_rst,
  input  wire logic         wr_en,
  input  wire logic [W-1:0] wr_data,
  input  wire logic         rd_en,
  output logic      [W-1:0] rd_data,
  output logic              full
);
  logic [W-1:0] mem_r;

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      mem_r <= '0;
    end else if (wr_en) begin
      mem_r <= wr_data;
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      rd_data <= '0;
    end else if (rd_en) begin
      rd_data <= mem_r;
    end
  end

  // Write wins so a new code arriving at take time is kept
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      full <= 1'b0;
    end else if (wr_en) begin
      full <= 1'b1;
    end else if (rd_en) begin
      full <= 1'b0;
    end
  end

  AST_HOLD_FILL: assert property (
    @(posedge mclk) disable iff (sys_rst)
    wr_en |=> full && mem_r == $past(wr_data))
    else $error("hold store did not capture code");
endmodule

`default_nettype wire

// *** design/tape_rx.sv ***
// Function
// - Marking idle line starts nothing.
// - Capture five data elements in order.
// - Halt after each frame, await start.
// - Accept one-unit stop elements too.
// - Baud is twice frequency; unit is 1/baud.
// - Support 22, 20, 17.5, 13.5 ms units.
// - Punch only data: mark is hole.
// - Start edge launches timed selecting cycle.
// - Near cycle end hand code to punch.
// - Selector idles until next start.
// - Punch outputs equal received data.
// - After punching, feed hole and advance.
// - Function cycle idles until triggered.
// - Punch code held apart from shifter.
// - Sampling point within element adjustable.
// - Function rate independent of line rate.
`timescale 1ns/100ps
`default_nettype none
`include "tape_rx_params.svh"

module tape_rx #(
  parameter int OVS       = `OVERSAMPLE,
  parameter int FUNC_TICK = `FUNC_TICK_CYC,
  parameter int TICK_455  = `TICK_CYC(`UNIT_US_455),
  parameter int TICK_500  = `TICK_CYC(`UNIT_US_500),
  parameter int TICK_569  = `TICK_CYC(`UNIT_US_569),
  parameter int TICK_742  = `TICK_CYC(`UNIT_US_742)
) (
  input  wire logic                mclk,
  input  wire logic                sys_rst,
  input  wire logic                line_in,
  input  wire tape_rx_pkg::rate_t  rate_sel,
  input  wire logic [3:0]          sample_pt,
  output logic [`DATA_BITS-1:0]    punch,
  output logic                     feed,
  output logic                     sel_busy,
  output logic                     fn_busy,
  output logic                     overrun
);
  localparam int NB = `DATA_BITS;

  default clocking dflt_cb @(posedge mclk);
  endclocking
  default disable iff (sys_rst);

  ////////////////////////////////////////////////////////////////////////
  // Line input synchroniser; a change counts when stages two and three agree
  logic s1_r, s2_r, s3_r, line_r;

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      s1_r <= 1'b1;
      s2_r <= 1'b1;
      s3_r <= 1'b1;
    end else begin
      s1_r <= line_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      line_r <= 1'b1;
    end else if (s2_r == s3_r) begin
      line_r <= s3_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Oversample tick at the selected line rate
  function automatic logic [23:0] tick_len(input tape_rx_pkg::rate_t r);
    case (r)
      2'h0:    tick_len = 24'(TICK_455);
      2'h1:    tick_len = 24'(TICK_500);
      2'h2:    tick_len = 24'(TICK_569);
      default: tick_len = 24'(TICK_742);
    endcase
  endfunction

  logic [23:0] div_r;
  logic        tick;
  tape_rx_pkg::sel_state_e sel_r;

  assign tick = (div_r == tick_len(rate_sel) - 24'h000001);

  // Divider restarts at the start edge so sampling is timed from it
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      div_r <= '0;
    end else if (sel_r == tape_rx_pkg::SEL_IDLE || tick) begin
      div_r <= '0;
    end else begin
      div_r <= div_r + 24'h000001;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Selecting cycle
  logic [3:0]    ph_r;
  logic [2:0]    bit_r;
  logic [NB-1:0] shift_r;
  logic          hand_r;
  logic [3:0]    spt;

  // Out-of-range points fall back to the element centre
  // Compared as int: OVS itself does not fit the 4-bit phase
  assign spt = (int'(sample_pt) < OVS) ? sample_pt : `SAMPLE_PT_RST;
  logic at_sample;
  assign at_sample = tick && ph_r == spt;

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      sel_r <= tape_rx_pkg::SEL_IDLE;
    end else begin
      case (sel_r)
        tape_rx_pkg::SEL_IDLE:
          if (!line_r) begin
            sel_r <= tape_rx_pkg::SEL_START;
          end
        tape_rx_pkg::SEL_START:
          if (at_sample) begin
            // Glitch that has ended by the start sample point is dropped
            sel_r <= line_r ? tape_rx_pkg::SEL_IDLE
                            : tape_rx_pkg::SEL_DATA;
          end
        tape_rx_pkg::SEL_DATA:
          if (at_sample && bit_r == 3'(NB - 1)) begin
            sel_r <= tape_rx_pkg::SEL_STOP;
          end
        tape_rx_pkg::SEL_STOP:
          // Halt at the stop sample; one-unit stops also fit
          if (at_sample) begin
            sel_r <= tape_rx_pkg::SEL_IDLE;
          end
        default: sel_r <= tape_rx_pkg::SEL_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      ph_r <= '0;
    end else if (sel_r == tape_rx_pkg::SEL_IDLE) begin
      ph_r <= '0;
    end else if (tick) begin
      ph_r <= (ph_r == 4'(OVS - 1)) ? 4'h0 : ph_r + 4'h1;
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      bit_r <= '0;
    end else if (sel_r != tape_rx_pkg::SEL_DATA) begin
      bit_r <= '0;
    end else if (at_sample) begin
      bit_r <= bit_r + 3'h1;
    end
  end

  // First element lands in bit 0; marking is 1
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      shift_r <= '0;
    end else if (sel_r == tape_rx_pkg::SEL_DATA && at_sample) begin
      shift_r[bit_r] <= line_r;
    end
  end

  // Hand-over at the last data sample, before the stop element
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      hand_r <= 1'b0;
    end else begin
      hand_r <= sel_r == tape_rx_pkg::SEL_DATA && at_sample
                && bit_r == 3'(NB - 1);
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      sel_busy <= 1'b0;
    end else begin
      sel_busy <= sel_r != tape_rx_pkg::SEL_IDLE;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Pending code store, one deep
  logic          take;
  logic          pend_full;
  logic [NB-1:0] pend_code;

  code_hold #(
    .W (NB)
  ) u_hold (
    .mclk    (mclk),
    .sys_rst (sys_rst),
    .wr_en   (hand_r),
    .wr_data (shift_r),
    .rd_en   (take),
    .rd_data (pend_code),
    .full    (pend_full)
  );

  // A second code while one waits replaces it and is flagged
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      overrun <= 1'b0;
    end else begin
      overrun <= hand_r && pend_full && !take;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Function cycle on its own fixed-rate timebase
  tape_rx_pkg::fn_state_e fn_r;
  logic [15:0] fdiv_r;
  logic [15:0] fcnt_r;
  logic        ftick;
  logic        load_r;

  assign ftick = fdiv_r == 16'(FUNC_TICK - 1);
  assign take  = fn_r == tape_rx_pkg::FN_IDLE && pend_full && !load_r;

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      fdiv_r <= '0;
    end else if (ftick || fn_r == tape_rx_pkg::FN_IDLE) begin
      fdiv_r <= '0;
    end else begin
      fdiv_r <= fdiv_r + 16'h0001;
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      load_r <= 1'b0;
    end else begin
      load_r <= take;
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      fcnt_r <= '0;
    end else if (fn_r == tape_rx_pkg::FN_IDLE) begin
      fcnt_r <= '0;
    end else if (ftick) begin
      fcnt_r <= fcnt_r + 16'h0001;
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      fn_r <= tape_rx_pkg::FN_IDLE;
    end else begin
      case (fn_r)
        tape_rx_pkg::FN_IDLE:
          if (load_r) begin
            fn_r <= tape_rx_pkg::FN_PUNCH;
          end
        tape_rx_pkg::FN_PUNCH:
          if (ftick && fcnt_r == `PUNCH_LEN - 16'h0001) begin
            fn_r <= tape_rx_pkg::FN_GAP;
          end
        tape_rx_pkg::FN_GAP:
          if (ftick && fcnt_r == `FEED_START - 16'h0001) begin
            fn_r <= tape_rx_pkg::FN_FEED;
          end
        tape_rx_pkg::FN_FEED:
          if (ftick && fcnt_r == `FUNC_LEN - 16'h0001) begin
            fn_r <= tape_rx_pkg::FN_IDLE;
          end
        default: fn_r <= tape_rx_pkg::FN_IDLE;
      endcase
    end
  end

  // Punch pins drive only while punching, from the held code
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      punch <= '0;
    end else if (fn_r == tape_rx_pkg::FN_PUNCH) begin
      punch <= pend_code;
    end else begin
      punch <= '0;
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      feed <= 1'b0;
    end else begin
      feed <= fn_r == tape_rx_pkg::FN_FEED;
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      fn_busy <= 1'b0;
    end else begin
      fn_busy <= fn_r != tape_rx_pkg::FN_IDLE;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks
  AST_IDLE_MARK: assert property (
    sel_r == tape_rx_pkg::SEL_IDLE && line_r
      |=> sel_r == tape_rx_pkg::SEL_IDLE)
    else $error("selector left idle on marking line");

  AST_START_GO: assert property (
    sel_r == tape_rx_pkg::SEL_IDLE && !line_r
      |=> sel_r == tape_rx_pkg::SEL_START)
    else $error("start element did not launch selection");

  AST_GLITCH: assert property (
    sel_r == tape_rx_pkg::SEL_START && at_sample && line_r
      |=> sel_r == tape_rx_pkg::SEL_IDLE)
    else $error("glitch start not rejected");

  AST_BIT_CAP: assert property (
    sel_r == tape_rx_pkg::SEL_DATA && at_sample
      |=> shift_r[$past(bit_r)] == $past(line_r))
    else $error("data element not captured");

  AST_HAND: assert property (
    hand_r |-> $past(sel_r) == tape_rx_pkg::SEL_DATA
      && sel_r == tape_rx_pkg::SEL_STOP)
    else $error("hand-over outside end of selection");

  AST_STOP_HALT: assert property (
    sel_r == tape_rx_pkg::SEL_STOP && at_sample
      |=> sel_r == tape_rx_pkg::SEL_IDLE)
    else $error("selector did not halt after stop");

  AST_PUNCH_CODE: assert property (
    $past(fn_r) == tape_rx_pkg::FN_PUNCH |-> punch == $past(pend_code))
    else $error("punch code differs from received code");

  AST_FEED_AFTER: assert property (
    $rose(feed) |-> $past(fn_r, 2) == tape_rx_pkg::FN_GAP)
    else $error("feed not after punching");

  AST_FN_IDLE: assert property (
    fn_r == tape_rx_pkg::FN_IDLE && !load_r
      |=> fn_r == tape_rx_pkg::FN_IDLE)
    else $error("function cycle ran untriggered");

  COV_FRAME: cover property (@(posedge mclk) hand_r);
  COV_GLITCH: cover property (@(posedge mclk)
    sel_r == tape_rx_pkg::SEL_START ##1 sel_r == tape_rx_pkg::SEL_IDLE);
  COV_OVERLAP: cover property (@(posedge mclk) sel_busy && fn_busy);
  COV_FEED: cover property (@(posedge mclk) $fell(feed));
endmodule

`default_nettype wire

// *** verif/line_sender.sv ***
`timescale 1ns/100ps
`default_nettype none

// Far-end sender; line holds marking whenever no frame is sent
module line_sender (
  input  wire logic mclk,
  output logic      line_in
);
  int unit_cyc;

  initial begin
    line_in  = 1'b1;
    unit_cyc = 32;
  end

  task automatic hold(input logic lvl, input int n);
    line_in <= lvl;
    repeat (n) @(posedge mclk);
  endtask

  // Stop is 1.42 units unless the short pattern is asked for
  task automatic send(input logic [4:0] code, input bit short_stop);
    hold(1'b0, unit_cyc);
    for (int i = 0; i < 5; i++) begin
      hold(code[i], unit_cyc);
    end
    hold(1'b1, short_stop ? unit_cyc : unit_cyc * 142 / 100);
  endtask
endmodule

`default_nettype wire

// *** verif/tape_rx_tb.sv ***
`timescale 1ns/100ps
`default_nettype none

module tape_rx_tb;
  // Clock cycles per oversample tick for each rate, shortened
  localparam int TK [4] = '{5, 4, 3, 2};
  localparam int FT     = 8;

  logic                mclk;
  logic                sys_rst;
  logic                line_in;
  tape_rx_pkg::rate_t  rate_sel;
  logic [3:0]          sample_pt;
  logic [4:0]          punch;
  logic                feed;
  logic                sel_busy;
  logic                fn_busy;
  logic                overrun;
  logic [4:0]          got_q[$];
  int                  fn_age;
  int                  ovr_count;
  int                  bad_count;
  int                  num_checks;

  tape_rx #(
    .FUNC_TICK (FT),
    .TICK_455  (TK[0]),
    .TICK_500  (TK[1]),
    .TICK_569  (TK[2]),
    .TICK_742  (TK[3])
  ) dut_u (
    .mclk      (mclk),
    .sys_rst   (sys_rst),
    .line_in   (line_in),
    .rate_sel  (rate_sel),
    .sample_pt (sample_pt),
    .punch     (punch),
    .feed      (feed),
    .sel_busy  (sel_busy),
    .fn_busy   (fn_busy),
    .overrun   (overrun)
  );

  line_sender tx_u (
    .mclk    (mclk),
    .line_in (line_in)
  );

  initial mclk = 1'b0;
  always #2.5 mclk = ~mclk;

  // Punch code taken on the second cycle of each function cycle
  always @(posedge mclk) begin
    fn_age <= (fn_busy === 1'b1) ? fn_age + 1 : 0;
    if (fn_age == 1) got_q.push_back(punch);
    if (overrun === 1'b1) ovr_count <= ovr_count + 1;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic fail(input string msg);
    bad_count++;
    $display("mismatch at %0t: %s", $time, msg);
  endtask

  task automatic check_code(input logic [4:0] got, input logic [4:0] exp);
    num_checks++;
    if (got !== exp) fail($sformatf("code %h expected %h", got, exp));
  endtask

  task automatic check_bit(input logic got, input logic exp, input string what);
    num_checks++;
    if (got !== exp) fail($sformatf("%s is %b", what, got));
  endtask

  task automatic check_num(input int got, input int exp, input string what);
    num_checks++;
    if (got != exp) fail($sformatf("%s %0d expected %0d", what, got, exp));
  endtask

  task automatic wait_q(input int n);
    int k;
    for (k = 0; k < 4000 && got_q.size() < n; k++) @(posedge mclk);
    if (got_q.size() < n) fail("no function cycle");
  endtask

  task automatic set_rate(input int r, input logic [3:0] pt);
    rate_sel  <= r[1:0];
    sample_pt <= pt;
    tx_u.unit_cyc = TK[r] * 16;
    @(posedge mclk);
  endtask

  task automatic finish_test;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_idle;
    set_rate(3, 4'h8);
    repeat (300) @(posedge mclk);
    check_bit(sel_busy, 1'b0, "sel_busy");
    check_bit(fn_busy, 1'b0, "fn_busy");
    check_num(got_q.size(), 0, "rows");
  endtask

  task automatic t_rates;
    logic [4:0] codes [4];
    int n;
    int k;
    codes = '{5'h15, 5'h0a, 5'h1e, 5'h01};
    for (int r = 0; r < 4; r++) begin
      set_rate(r, (r == 1) ? 4'h5 : 4'h8);
      n = got_q.size();
      tx_u.send(codes[r], 1'b0);
      wait_q(n + 1);
      check_code(got_q[n], codes[r]);
      for (k = 0; k < FT * 40 && feed !== 1'b1; k++) @(posedge mclk);
      check_bit(feed, 1'b1, "feed");
      check_code(punch, 5'h00);
      for (k = 0; k < FT * 40 && fn_busy !== 1'b0; k++) @(posedge mclk);
      check_bit(fn_busy, 1'b0, "fn_busy");
      check_bit(sel_busy, 1'b0, "sel_busy");
    end
  endtask

  // Elements half one level, half the other; sample point picks the half
  task automatic t_sample;
    logic [4:0] c;
    int n;
    int k;
    c = 5'h19;
    for (int p = 0; p < 2; p++) begin
      set_rate(3, (p == 0) ? 4'h4 : 4'hc);
      n = got_q.size();
      tx_u.hold(1'b0, 32);
      check_bit(sel_busy, 1'b1, "sel_busy");
      for (int i = 0; i < 5; i++) begin
        tx_u.hold(c[i], 16);
        tx_u.hold(~c[i], 16);
      end
      tx_u.hold(1'b1, 46);
      wait_q(n + 1);
      check_code(got_q[n], (p == 0) ? c : ~c);
      for (k = 0; k < FT * 60 && fn_busy !== 1'b0; k++) @(posedge mclk);
    end
  endtask

  // Low pulse shorter than half a unit must not start a frame
  task automatic t_glitch;
    int n;
    set_rate(3, 4'h8);
    n = got_q.size();
    tx_u.hold(1'b0, 6);
    tx_u.hold(1'b1, 400);
    check_num(got_q.size(), n, "rows");
    check_bit(sel_busy, 1'b0, "sel_busy");
  endtask

  // Five short-stop frames back to back; fourth code overwritten
  task automatic t_b2b;
    logic [4:0] c [5];
    int n;
    int o;
    c = '{5'h15, 5'h0a, 5'h1f, 5'h03, 5'h10};
    set_rate(3, 4'h8);
    n = got_q.size();
    o = ovr_count;
    for (int i = 0; i < 5; i++) tx_u.send(c[i], 1'b1);
    wait_q(n + 4);
    repeat (800) @(posedge mclk);
    check_num(got_q.size(), n + 4, "rows");
    check_code(got_q[n], c[0]);
    check_code(got_q[n + 1], c[1]);
    check_code(got_q[n + 2], c[2]);
    check_code(got_q[n + 3], c[4]);
    check_num(ovr_count - o, 1, "overruns");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    sys_rst    = 1'b1;
    rate_sel   = 2'h3;
    sample_pt  = 4'h8;
    fn_age     = 0;
    ovr_count  = 0;
    bad_count  = 0;
    num_checks = 0;
    repeat (5) @(posedge mclk);
    sys_rst <= 1'b0;
    @(posedge mclk);
    t_idle();
    t_rates();
    t_sample();
    t_glitch();
    t_b2b();
    finish_test();
  end

  // Whole run needs well under 20000 cycles
  initial begin
    #100000;
    fail("watchdog expired");
    finish_test();
  end
endmodule

`default_nettype wire
